// >>> rtl/rpsr_top.v
// Pin routing of the real-time clock: input monitors, reset forward, output muxes
// Function
// - External interrupt pin raises interrupt one when enabled, polarity bit selects level.
// - External interrupt pin level is readable by software in a status bit.
// - Watchdog pin feeds watchdog reset and raises interrupt two with own polarity.
// - Watchdog pin level is readable by software in a status bit.
// - Low external reset with forwarding enabled asserts reset output per polarity.
// - Software select field chooses what drives the primary interrupt pin.
// - Primary sources: static bit, inverted combined, square wave if enabled, inverted alarm.
// - Primary pin held low after power-up until the ready count runs out; the bus answers from reset release.
// - Second software select field chooses what drives the secondary pin.
// - Secondary sources: static, square wave, inverted combined or alarm, timer either sense.
// - Power-switch mode makes secondary pin a sleep-controlled power switch.
// - Timer pin always carries the active-low timer interrupt.
// - Clock pin carries static primary bit or square wave when enabled.
// - Reset polarity bit clears at power-up, giving an active-low reset output.
`timescale 1ns/1ps
`include "rpsr_regs.vh"
module rpsr_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Interrupt
  output reg         irq_o,
  // Input pins
  input  wire        ext_irq1_pin_i,
  input  wire        watchdog_kick_pin_i,
  input  wire        ext_reset_pin_n_i,
  // Internal signal sources
  input  wire        combined_irq_i,
  input  wire        alarm_interrupt_i,
  input  wire        timer_interrupt_i,
  input  wire        square_wave_i,
  input  wire        sleep_power_on_i,
  // Monitor results to other blocks
  output reg         watchdog_kick_o,
  output reg         ext1_irq_o,
  output reg         ext2_irq_o,
  // Open-drain pins, enable low while pulling low
  output reg         primary_irq_pin_o,
  output reg         primary_irq_pin_oe_n_o,
  output reg         secondary_irq_pin_o,
  output reg         secondary_irq_pin_oe_n_o,
  output reg         power_switch_on_o,
  output reg         timer_irq_pin_n_o,
  output reg         timer_irq_pin_oe_n_o,
  output reg         reset_output_pin_o,
  output reg         reset_output_pin_oe_n_o,
  // Push-pull clock pin
  output reg         clock_pin_o
);

  reg  [`RPSR_CTRL_WIDTH-1:0] ctrl;
  reg  [`RPSR_SEL_WIDTH-1:0]  sel;
  reg  [`RPSR_IRQ_WIDTH-1:0]  irq_status;
  reg  [`RPSR_IRQ_WIDTH-1:0]  irq_mask;
  reg  [`RPSR_READY_CNT_W-1:0] ready_cnt;
  reg                          ready;
  reg                          rst_pin_q;
  reg  [31:0]                  next_rdata;
  reg                          next_primary;
  reg                          next_secondary;
  reg  [`RPSR_IRQ_WIDTH-1:0]   next_status;
  wire                         ext1_level;
  wire                         wdog_level;
  wire                         ext1_event;
  wire                         ext2_event;
  wire                         rst_event;
  wire                         bus_req;
  wire                         wr_acc;
  wire                         rd_status;
  wire                         rst_active;
  wire [1:0]                   pri_sel;
  wire [2:0]                   sec_sel;
  wire                         sqw_en;
  wire                         sqw_gated;

  localparam [31:0] READY_LAST_W = `RPSR_READY_CYC - 1;
  localparam [`RPSR_READY_CNT_W-1:0] READY_LAST = READY_LAST_W[`RPSR_READY_CNT_W-1:0];

  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_acc    = bus_req & wb_we_i;
  assign rd_status = bus_req & ~wb_we_i & (wb_adr_i == `RPSR_ADDR_IRQ_STATUS);
  assign pri_sel   = sel[`RPSR_SEL_PRI_MSB:`RPSR_SEL_PRI_LSB];
  assign sec_sel   = sel[`RPSR_SEL_SEC_MSB:`RPSR_SEL_SEC_LSB];
  assign sqw_en    = ctrl[`RPSR_CTRL_SQW_EN];
  // Disabled square wave leaves the pin released rather than toggling
  assign sqw_gated = sqw_en ? square_wave_i : 1'b1;
  assign rst_active = ~ext_reset_pin_n_i & ctrl[`RPSR_CTRL_RST_FWD_EN];
  assign rst_event  = rst_active & ~rst_pin_q;

  // External interrupt one monitor
  rpsr_ext_mon u_ext1 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (ext_irq1_pin_i),
    .enable_i   (ctrl[`RPSR_CTRL_EXT1_EN]),
    .polarity_i (ctrl[`RPSR_CTRL_EXT1_POL]),
    .level_o    (ext1_level),
    .event_o    (ext1_event)
  );

  // Watchdog pin doubles as interrupt two
  rpsr_ext_mon u_ext2 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (watchdog_kick_pin_i),
    .enable_i   (ctrl[`RPSR_CTRL_EXT2_EN]),
    .polarity_i (ctrl[`RPSR_CTRL_EXT2_POL]),
    .level_o    (wdog_level),
    .event_o    (ext2_event)
  );

  // Register read data
  always @* begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `RPSR_ADDR_CTRL: begin
        next_rdata[`RPSR_CTRL_WIDTH-1:0] = ctrl;
      end
      `RPSR_ADDR_SELECT: begin
        next_rdata[`RPSR_SEL_WIDTH-1:0] = sel;
      end
      `RPSR_ADDR_PINS: begin
        next_rdata[`RPSR_PINS_EXT1]    = ext1_level;
        next_rdata[`RPSR_PINS_WDOG]    = wdog_level;
        next_rdata[`RPSR_PINS_EXT_RST] = rst_pin_q;
        next_rdata[`RPSR_PINS_READY]   = ready;
      end
      `RPSR_ADDR_IRQ_STATUS: begin
        next_rdata[`RPSR_IRQ_WIDTH-1:0] = irq_status;
      end
      `RPSR_ADDR_IRQ_MASK: begin
        next_rdata[`RPSR_IRQ_WIDTH-1:0] = irq_mask;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Bus slave: one wait state, ack for every address
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data stands only with ack, zero otherwise
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
    end
  end

  // Writable registers, low byte lane and second lane
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= `RPSR_CTRL_RESET;
      sel      <= `RPSR_SEL_RESET;
      irq_mask <= `RPSR_IRQ_RESET;
    end else if (wr_acc) begin
      case (wb_adr_i)
        `RPSR_ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            ctrl[`RPSR_CTRL_WIDTH-1:8] <= wb_dat_i[`RPSR_CTRL_WIDTH-1:8];
          end
        end
        `RPSR_ADDR_SELECT: begin
          if (wb_sel_i[0]) begin
            sel <= wb_dat_i[`RPSR_SEL_WIDTH-1:0];
          end
        end
        `RPSR_ADDR_IRQ_MASK: begin
          if (wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[`RPSR_IRQ_WIDTH-1:0];
          end
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // Sticky status, read clears, a new event in the same cycle wins
  always @* begin
    next_status = rd_status ? `RPSR_IRQ_RESET : irq_status;
    next_status[`RPSR_IRQ_EXT1]    = next_status[`RPSR_IRQ_EXT1] | ext1_event;
    next_status[`RPSR_IRQ_EXT2]    = next_status[`RPSR_IRQ_EXT2] | ext2_event;
    next_status[`RPSR_IRQ_EXT_RST] = next_status[`RPSR_IRQ_EXT_RST] | rst_event;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= `RPSR_IRQ_RESET;
    end else begin
      irq_status <= next_status;
    end
  end

  // Level interrupt follows the status about to be held, not the old one
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & irq_mask);
    end
  end

  // Forwarding state of last cycle, for the start-of-forwarding event
  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_pin_q <= 1'b0;
    end else begin
      rst_pin_q <= rst_active;
    end
  end

  // Power-up hold: ready sets once the counter has run out; the bus answers from reset release
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_cnt <= {`RPSR_READY_CNT_W{1'b0}};
      ready     <= 1'b0;
    end else if (!ready) begin
      ready_cnt <= ready_cnt + 1'b1;
      ready     <= (ready_cnt == READY_LAST);
    end
  end

  // Primary pin source selection
  always @* begin
    case (pri_sel)
      `RPSR_PRI_STATIC:  next_primary = ctrl[`RPSR_CTRL_PRI_LEVEL];
      `RPSR_PRI_IRQ_N:   next_primary = ~combined_irq_i;
      `RPSR_PRI_SQW:     next_primary = sqw_gated;
      `RPSR_PRI_ALARM_N: next_primary = ~alarm_interrupt_i;
      default:           next_primary = 1'b1;
    endcase
  end

  // Secondary pin source selection, unused codes fall back to the static bit
  always @* begin
    case (sec_sel)
      `RPSR_SEC_STATIC:  next_secondary = ctrl[`RPSR_CTRL_SEC_LEVEL];
      `RPSR_SEC_SQW:     next_secondary = sqw_gated;
      `RPSR_SEC_IRQ_N:   next_secondary = ~combined_irq_i;
      `RPSR_SEC_ALARM_N: next_secondary = ~alarm_interrupt_i;
      `RPSR_SEC_TIMER:   next_secondary = timer_interrupt_i;
      `RPSR_SEC_TIMER_N: next_secondary = ~timer_interrupt_i;
      default:           next_secondary = ctrl[`RPSR_CTRL_SEC_LEVEL];
    endcase
  end

  // Primary pin; open-drain data stays low, the enable carries the level
  always @(posedge clk_i) begin
    if (rst_i) begin
      primary_irq_pin_o      <= 1'b0;
      primary_irq_pin_oe_n_o <= 1'b0;
    end else begin
      primary_irq_pin_o      <= 1'b0;
      // Held low until ready so the host can poll for access
      primary_irq_pin_oe_n_o <= ready & next_primary;
    end
  end

  // Secondary pin, or a switch that pulls the rail low for the external load
  always @(posedge clk_i) begin
    if (rst_i) begin
      secondary_irq_pin_o      <= 1'b0;
      secondary_irq_pin_oe_n_o <= 1'b1;
      power_switch_on_o        <= 1'b0;
    end else if (ctrl[`RPSR_CTRL_PSW_MODE]) begin
      secondary_irq_pin_o      <= 1'b0;
      secondary_irq_pin_oe_n_o <= ~sleep_power_on_i;
      power_switch_on_o        <= sleep_power_on_i;
    end else begin
      secondary_irq_pin_o      <= 1'b0;
      secondary_irq_pin_oe_n_o <= next_secondary;
      power_switch_on_o        <= 1'b0;
    end
  end

  // Timer pin, no selection; data mirrors the enable so it idles high
  always @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_pin_n_o    <= 1'b1;
      timer_irq_pin_oe_n_o <= 1'b1;
    end else begin
      timer_irq_pin_n_o    <= ~timer_interrupt_i;
      timer_irq_pin_oe_n_o <= ~timer_interrupt_i;
    end
  end

  // Reset output; asserted level equals the polarity bit, idle its inverse
  always @(posedge clk_i) begin
    if (rst_i) begin
      reset_output_pin_o      <= 1'b0;
      reset_output_pin_oe_n_o <= 1'b1;
    end else begin
      reset_output_pin_o      <= 1'b0;
      reset_output_pin_oe_n_o <= rst_active ? ctrl[`RPSR_CTRL_RST_POL]
                                            : ~ctrl[`RPSR_CTRL_RST_POL];
    end
  end

  // Push-pull clock pin
  always @(posedge clk_i) begin
    if (rst_i) begin
      clock_pin_o <= 1'b0;
    end else begin
      clock_pin_o <= ctrl[`RPSR_CTRL_CLK_SEL] ? sqw_gated
                                              : ctrl[`RPSR_CTRL_PRI_LEVEL];
    end
  end

  // Monitor results for the watchdog and interrupt blocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_kick_o <= 1'b0;
      ext1_irq_o      <= 1'b0;
      ext2_irq_o      <= 1'b0;
    end else begin
      watchdog_kick_o <= wdog_level;
      ext1_irq_o      <= ext1_event;
      ext2_irq_o      <= ext2_event;
    end
  end

endmodule

// >>> rtl/rpsr_regs.vh
// Register offsets, field positions, reset values and timing counts of the pin router
`ifndef RPSR_REGS_VH
`define RPSR_REGS_VH

// Register byte offsets
`define RPSR_ADDR_CTRL        8'h00
`define RPSR_ADDR_SELECT      8'h04
`define RPSR_ADDR_PINS        8'h08
`define RPSR_ADDR_IRQ_STATUS  8'h0C
`define RPSR_ADDR_IRQ_MASK    8'h10

// Control register fields
`define RPSR_CTRL_EXT1_EN     0
`define RPSR_CTRL_EXT1_POL    1
`define RPSR_CTRL_EXT2_EN     2
`define RPSR_CTRL_EXT2_POL    3
`define RPSR_CTRL_RST_FWD_EN  4
`define RPSR_CTRL_RST_POL     5
`define RPSR_CTRL_SQW_EN      6
`define RPSR_CTRL_PSW_MODE    7
`define RPSR_CTRL_PRI_LEVEL   8
`define RPSR_CTRL_SEC_LEVEL   9
`define RPSR_CTRL_CLK_SEL     10
`define RPSR_CTRL_WIDTH       11
`define RPSR_CTRL_RESET       11'h300

// Select register fields
`define RPSR_SEL_PRI_LSB      0
`define RPSR_SEL_PRI_MSB      1
`define RPSR_SEL_SEC_LSB      4
`define RPSR_SEL_SEC_MSB      6
`define RPSR_SEL_WIDTH        7
`define RPSR_SEL_RESET        7'h00

// Primary pin source codes
`define RPSR_PRI_STATIC       2'h0
`define RPSR_PRI_IRQ_N        2'h1
`define RPSR_PRI_SQW          2'h2
`define RPSR_PRI_ALARM_N      2'h3

// Secondary pin source codes
`define RPSR_SEC_STATIC       3'h0
`define RPSR_SEC_SQW          3'h1
`define RPSR_SEC_IRQ_N        3'h2
`define RPSR_SEC_ALARM_N      3'h3
`define RPSR_SEC_TIMER        3'h4
`define RPSR_SEC_TIMER_N      3'h5

// Pin level register fields
`define RPSR_PINS_EXT1        0
`define RPSR_PINS_WDOG        1
`define RPSR_PINS_EXT_RST     2
`define RPSR_PINS_READY       3

// Interrupt status and mask fields
`define RPSR_IRQ_EXT1         0
`define RPSR_IRQ_EXT2         1
`define RPSR_IRQ_EXT_RST      2
`define RPSR_IRQ_WIDTH        3
`define RPSR_IRQ_RESET        3'h0

// Power-up hold of the primary pin
`define RPSR_CLK_MHZ          200
`define RPSR_READY_NS         80
`define RPSR_READY_CYC        ((`RPSR_READY_NS * `RPSR_CLK_MHZ + 999) / 1000)
`define RPSR_READY_CNT_W      5

`endif

// >>> rtl/rpsr_ext_mon.v
// External input pin monitor: level capture and polarity-qualified event
`timescale 1ns/1ps
module rpsr_ext_mon (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Pin and configuration
  input  wire pin_i,
  input  wire enable_i,
  input  wire polarity_i,
  // Results
  output reg  level_o,
  output reg  event_o
);

  wire active;

  // Polarity 1 means high is the active level
  assign active = ~(pin_i ^ polarity_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      event_o <= 1'b0;
    end else begin
      level_o <= pin_i;
      // Edge into the active level only, so a held level fires once
      event_o <= enable_i & active & ~(~(level_o ^ polarity_i));
    end
  end

endmodule

// >>> tb/rpsr_properties.sv
// Port checker of the pin router, bound to its top
`timescale 1ns/1ps
module rpsr_checker (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  // Sources
  input wire        watchdog_kick_pin_i,
  input wire        timer_interrupt_i,
  input wire        sleep_power_on_i,
  // Results and pins
  input wire        watchdog_kick_o,
  input wire        ext1_irq_o,
  input wire        ext2_irq_o,
  input wire        power_switch_on_o,
  input wire        primary_irq_pin_oe_n_o,
  input wire        primary_irq_pin_o,
  input wire        secondary_irq_pin_o,
  input wire        reset_output_pin_o,
  input wire        timer_irq_pin_n_o,
  input wire        timer_irq_pin_oe_n_o
);
  reg [4:0] up_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since reset release, saturating
  always @(posedge clk_i)
    if (rst_i)
      up_cnt <= 5'h00;
    else if (up_cnt != 5'h1F)
      up_cnt <= up_cnt + 5'h01;
  AST_ACK_TAKEN: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_TIMER_PIN: assert property (1 |=> timer_irq_pin_oe_n_o == !$past(timer_interrupt_i))
    else $error("timer pin not following timer source");
  AST_WDOG_COPY: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    watchdog_kick_o == $past(watchdog_kick_pin_i, 2))
    else $error("watchdog copy wrong");
  AST_PSW_CAUSE: assert property (power_switch_on_o |-> $past(sleep_power_on_i))
    else $error("power switch on without sleep control");
  // Held low through the whole ready count and the pin flop after it
  AST_PRI_HOLD: assert property (up_cnt < 5'h11 |-> !primary_irq_pin_oe_n_o)
    else $error("primary pin released too early");
  AST_OD_DATA_LOW: assert property (!primary_irq_pin_o && !secondary_irq_pin_o
    && !reset_output_pin_o)
    else $error("open-drain data not low");
  AST_TIMER_DATA: assert property (timer_irq_pin_n_o == timer_irq_pin_oe_n_o)
    else $error("timer pin data and enable differ");
  AST_EXT1_PULSE: assert property (ext1_irq_o |=> !ext1_irq_o)
    else $error("event one pulse too long");
  AST_EXT2_PULSE: assert property (ext2_irq_o |=> !ext2_irq_o)
    else $error("event two pulse too long");
endmodule

bind rpsr_top rpsr_checker rpsr_checker_i (.*);

// >>> tb/rpsr_host_model.sv
// Host side of the router pins: pull-ups and idle chip select
`timescale 1ns/1ps
module rpsr_host_model (
  // Pin drivers from the router
  input  wire primary_oe_n_i,
  input  wire secondary_oe_n_i,
  input  wire timer_oe_n_i,
  input  wire reset_oe_n_i,
  // Levels the host sees
  output wire primary_o,
  output wire secondary_o,
  output wire timer_o,
  output wire reset_o,
  output wire spi_select_n_o
);
  // Released pins read high through the pull-ups
  assign primary_o      = primary_oe_n_i ? 1'b1 : 1'b0;
  assign secondary_o    = secondary_oe_n_i ? 1'b1 : 1'b0;
  assign timer_o        = timer_oe_n_i ? 1'b1 : 1'b0;
  assign reset_o        = reset_oe_n_i ? 1'b1 : 1'b0;
  // Held high so no stray write during power changes
  assign spi_select_n_o = 1'b1;
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the pin router
`timescale 1ns/1ps
`include "rpsr_regs.vh"
module testbench;
  reg         clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wd = 32'h0, rd;
  reg         ext1 = 1'b0, wdog = 1'b0, xrst_n = 1'b1, comb = 1'b0;
  reg         alarm = 1'b0, timer = 1'b0, sqw = 1'b0, sleep = 1'b0;
  wire [31:0] rdo;
  wire        ack, irq, pri_oe, sec_oe, tmr_oe, rst_oe, clk_pin, psw;
  wire        pri, sec, tmr, rso, cs_n, e1, e2;
  integer     bad_count = 0, n_tests = 0, i;
  rpsr_top rpsr_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdo), .wb_ack_o(ack),
    .irq_o(irq), .ext_irq1_pin_i(ext1), .watchdog_kick_pin_i(wdog),
    .ext_reset_pin_n_i(xrst_n), .combined_irq_i(comb), .alarm_interrupt_i(alarm),
    .timer_interrupt_i(timer), .square_wave_i(sqw), .sleep_power_on_i(sleep),
    .watchdog_kick_o(), .ext1_irq_o(e1), .ext2_irq_o(e2), .primary_irq_pin_o(),
    .primary_irq_pin_oe_n_o(pri_oe), .secondary_irq_pin_o(),
    .secondary_irq_pin_oe_n_o(sec_oe), .power_switch_on_o(psw),
    .timer_irq_pin_n_o(), .timer_irq_pin_oe_n_o(tmr_oe), .reset_output_pin_o(),
    .reset_output_pin_oe_n_o(rst_oe), .clock_pin_o(clk_pin));
  rpsr_host_model rpsr_host_model_i (
    .primary_oe_n_i(pri_oe), .secondary_oe_n_i(sec_oe), .timer_oe_n_i(tmr_oe),
    .reset_oe_n_i(rst_oe), .primary_o(pri), .secondary_o(sec), .timer_o(tmr),
    .reset_o(rso), .spi_select_n_o(cs_n));
  always #2.5 clk_i = ~clk_i;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; ack is sampled at the edge, never assumed
  task wb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk_i);
      req <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      for (k = 0; k < 40 && ack !== 1'b1; k = k + 1)
        @(posedge clk_i);
      if (ack !== 1'b1) begin
        chk(32'h0, 32'h1);
        tally_and_finish;
      end
      rd = rdo;
      req <= 1'b0;
    end
  endtask
  task s_reset;
    begin
      tick(1);
      chk(pri, 1'b0);
      chk(rso, 1'b1);
      chk(cs_n, 1'b1);
      wb(0, `RPSR_ADDR_CTRL, 0);
      chk(rd, 32'h300);
      tick(20);
      chk(pri, 1'b1);
      timer <= 1'b1;
      tick(2);
      chk(tmr, 1'b0);
    end
  endtask
  // Same expected pattern fits both muxes, code i in the secondary field, i mod 4 in the primary
  task s_mux;
    begin
      comb <= 1'b1;
      wb(1, `RPSR_ADDR_CTRL, 32'h340);
      for (i = 0; i < 6; i = i + 1) begin
        wb(1, `RPSR_ADDR_SELECT, (i << 4) | (i & 3));
        tick(2);
        chk(pri, 6'b011001 >> i & 1);
        chk(sec, 6'b011001 >> i & 1);
      end
      chk(clk_pin, 1'b1);
      wb(1, `RPSR_ADDR_CTRL, 32'h740);
      tick(2);
      chk(clk_pin, 1'b0);
      wb(1, `RPSR_ADDR_SELECT, 32'h12);
      wb(1, `RPSR_ADDR_CTRL, 32'h300);
      tick(2);
      chk({pri, sec}, 2'b11);
      sqw <= 1'b1;
      wb(1, `RPSR_ADDR_CTRL, 32'h640);
      tick(2);
      chk({pri, sec, clk_pin}, 3'b111);
      sqw <= 1'b0;
      tick(2);
      chk({pri, sec, clk_pin}, 3'b000);
    end
  endtask
  task s_rst;
    begin
      xrst_n <= 1'b0;
      tick(2);
      chk(rso, 1'b1);
      wb(1, `RPSR_ADDR_CTRL, 32'h310);
      tick(2);
      chk(rso, 1'b0);
      wb(1, `RPSR_ADDR_CTRL, 32'h330);
      tick(2);
      chk(rso, 1'b1);
      xrst_n <= 1'b1;
      tick(2);
      chk(rso, 1'b0);
    end
  endtask
  task s_irq;
    begin
      wb(1, `RPSR_ADDR_IRQ_MASK, 32'h7);
      wb(1, `RPSR_ADDR_CTRL, 32'h307);
      wb(0, `RPSR_ADDR_IRQ_STATUS, 0);
      chk(rd, 32'h4);
      tick(2);
      chk(irq, 1'b0);
      ext1 <= 1'b1;
      wdog <= 1'b1;
      tick(3);
      chk(irq, 1'b1);
      chk(e1, 1'b1);
      wb(0, `RPSR_ADDR_PINS, 0);
      chk(rd[1:0], 2'b11);
      wb(0, `RPSR_ADDR_IRQ_STATUS, 0);
      chk(rd, 32'h1);
      tick(2);
      chk(irq, 1'b0);
      wdog <= 1'b0;
      wb(1, `RPSR_ADDR_IRQ_MASK, 32'h0);
      chk(e2, 1'b1);
      ext1 <= 1'b0;
      tick(3);
      chk(irq, 1'b0);
      wb(0, `RPSR_ADDR_IRQ_STATUS, 0);
      chk(rd, 32'h2);
    end
  endtask
  task s_misc;
    begin
      wb(1, 8'h20, 32'hFFFFFFFF);
      wb(0, 8'h20, 0);
      chk(rd, 32'h0);
      wb(1, `RPSR_ADDR_CTRL, 32'h380);
      sleep <= 1'b1;
      tick(2);
      chk({psw, sec}, 2'b10);
      sleep <= 1'b0;
      tick(2);
      chk(psw, 1'b0);
    end
  endtask
  initial begin
    tick(8);
    rst_i <= 1'b0;
    s_reset;
    s_mux;
    s_rst;
    s_irq;
    s_misc;
    tally_and_finish;
  end
endmodule
